// >>> core/sied_pkg.sv
// Purpose: Shared constants for the input enable and direction block
// Assumes: 200 MHz system clock, 32-bit serial frames
// Notes: Frame is write flag, 6-bit address, 24-bit data, 1 spare bit
package sied_pkg;
    localparam int CH_N = 24;
    localparam int DIR_N = 10;
    localparam int FRAME_BITS = 32;
    localparam int ADDR_W = 6;
    localparam int WR_BIT = 31;
    localparam int ADDR_LSB = 25;
    localparam int DATA_LSB = 1;
    localparam logic [5:0] ADDR_CHAN_EN = 6'h1B;
    localparam logic [5:0] ADDR_DIR_SEL = 6'h1C;
    localparam logic [23:0] CHAN_EN_RST = 24'h00_0000;
    localparam logic [9:0] DIR_SEL_RST = 10'h000;
    localparam logic [23:0] RD_ZERO = 24'h00_0000;
    localparam logic CURRENT_SOURCE_MODE = 1'b0;
    localparam logic [4:0] BIT_LAST = 5'h1F;
    localparam int CLK_PERIOD_NS = 5;
    localparam int SLOT_TIME_NS = 64000;
    localparam int SLOT_CYCLES =
        (SLOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// >>> core/sied_poll_seq.sv
// Purpose: Polling sequencer stepping over enabled channels only
// Assumes: Inputs come from logic on sys_clk
// Notes: One sample strobe per slot, none if no channel is enabled
`timescale 1ns/1ps
`default_nettype none
module sied_poll_seq #(
    parameter int SLOT_CYCLES = sied_pkg::SLOT_CYCLES,
    parameter int CH_N = sied_pkg::CH_N
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [CH_N-1:0] chan_en,
    input wire logic run,
    input wire logic poll_en,
    output logic [4:0] chan_q,
    output logic sample_q,
    output logic continuous_q
);
    localparam int CNT_W = $clog2(SLOT_CYCLES + 1);
    localparam logic [CNT_W-1:0] SLOT_LAST = CNT_W'(SLOT_CYCLES - 1);

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_SCAN, SEQ_CONT} sied_seq_t;

    // -------------------------------------------------
    // Next enabled channel after the current one
    // -------------------------------------------------
    function automatic logic [5:0] next_chan(input logic [CH_N-1:0] en,
                                             input logic [4:0] cur);
        logic [5:0] r;
        int idx;
        r = 6'h00;
        for (int i = CH_N; i >= 1; i--)
        begin
            idx = (int'(cur) + i) % CH_N;
            if (en[idx])
                r = {1'b1, 5'(idx)};
        end
        return r;
    endfunction

    sied_seq_t state_q, state_d;
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic [4:0] chan_d;
    logic sample_d;
    wire logic slot_done = (cnt_q == SLOT_LAST);
    wire logic [5:0] pick = next_chan(chan_en, chan_q);

    always_comb
    begin
        case ({run, poll_en})
            2'h3: state_d = SEQ_SCAN;
            2'h2: state_d = SEQ_CONT;
            default: state_d = SEQ_IDLE;
        endcase
    end

    // Disabled channels are never picked
    assign sample_d = (state_q == SEQ_SCAN) && (state_d == SEQ_SCAN) &&
                      slot_done && pick[5];
    assign chan_d = sample_d ? pick[4:0] : chan_q;
    assign cnt_d = (state_d != SEQ_SCAN || slot_done) ? '0 :
                   cnt_q + CNT_W'(1);

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= SEQ_IDLE;
            cnt_q <= '0;
            // First pick after reset lands on the lowest enabled channel
            chan_q <= 5'(CH_N - 1);
            sample_q <= 1'b0;
            continuous_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            chan_q <= chan_d;
            sample_q <= sample_d;
            continuous_q <= (state_d == SEQ_CONT);
        end
    end

    // -------------------------------------------------
    // Checks
    // -------------------------------------------------
    a_sample_enabled: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        sample_q && $stable(chan_en) |-> chan_en[chan_q])
        else $error("sampled a disabled channel");
    a_none_no_sample: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        chan_en == '0 |=> !sample_q)
        else $error("sample with no channel enabled");
    a_poll_off_quiet: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        (!run || !poll_en) |=> !sample_q)
        else $error("polling while polling disabled");
    a_cont_mode: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        run && !poll_en |=> continuous_q && !sample_q)
        else $error("continuous mode not entered");
endmodule
`default_nettype wire

// >>> core/sied_top.sv
// Purpose: Channel enable and source/sink select registers on serial link
// Assumes: Host stops operation before reconfiguring; gap between frames
// Notes: Reply to a frame is shifted out during the next frame
`timescale 1ns/1ps
`default_nettype none
module sied_top #(
    parameter int SLOT_CYCLES = sied_pkg::SLOT_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic spi_sclk,
    input wire logic spi_cs_n,
    input wire logic spi_mosi,
    output logic spi_miso_o,
    output logic spi_miso_oe,
    input wire logic op_trigger,
    input wire logic poll_enable,
    output logic [sied_pkg::CH_N-1:0] chan_enable,
    output logic [sied_pkg::DIR_N-1:0] source_sink_choice_bit,
    output logic [4:0] poll_chan,
    output logic poll_sample,
    output logic continuous_mode
);
    // -------------------------------------------------
    // Reset release
    // -------------------------------------------------
    logic [1:0] rst_pipe_q;
    wire logic rst_sync_n = rst_pipe_q[1];

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            rst_pipe_q <= 2'h0;
        else
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
    end

    // -------------------------------------------------
    // Link side, on the serial clock
    // -------------------------------------------------
    // Chip select doubles as frame reset so a torn frame never lingers
    wire logic frm_rst_n = rst_n & ~spi_cs_n;
    logic [4:0] bit_cnt_q;
    logic [sied_pkg::FRAME_BITS-2:0] shift_q;
    logic [sied_pkg::FRAME_BITS-1:0] frame_q;
    logic req_tgl_q;
    logic miso_q;
    logic [sied_pkg::FRAME_BITS-1:0] reply_q;
    wire logic last_bit = (bit_cnt_q == sied_pkg::BIT_LAST);

    always_ff @(posedge spi_sclk or negedge frm_rst_n)
    begin
        if (!frm_rst_n)
        begin
            bit_cnt_q <= 5'h00;
            shift_q <= '0;
        end
        else
        begin
            bit_cnt_q <= bit_cnt_q + 5'h01;
            shift_q <= {shift_q[sied_pkg::FRAME_BITS-3:0], spi_mosi};
        end
    end

    always_ff @(posedge spi_sclk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            frame_q <= '0;
            req_tgl_q <= 1'b0;
        end
        else if (last_bit)
        begin
            frame_q <= {shift_q, spi_mosi};
            req_tgl_q <= ~req_tgl_q;
        end
    end

    // Reply word changes only between frames, so it is read without sync
    always_ff @(negedge spi_sclk or negedge frm_rst_n)
    begin
        if (!frm_rst_n)
            miso_q <= 1'b0;
        else
            miso_q <= reply_q[sied_pkg::BIT_LAST - bit_cnt_q];
    end

    assign spi_miso_o = miso_q;
    assign spi_miso_oe = ~spi_cs_n;

    // -------------------------------------------------
    // Frame event into the system clock
    // -------------------------------------------------
    logic [2:0] tgl_sync_q;
    wire logic frame_ev = tgl_sync_q[2] ^ tgl_sync_q[1];

    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
            tgl_sync_q <= 3'h0;
        else
            tgl_sync_q <= {tgl_sync_q[1:0], req_tgl_q};
    end

    // -------------------------------------------------
    // Register decode
    // -------------------------------------------------
    wire logic fr_wr = frame_q[sied_pkg::WR_BIT];
    wire logic [sied_pkg::ADDR_W-1:0] fr_addr =
        frame_q[sied_pkg::WR_BIT-1:sied_pkg::ADDR_LSB];
    wire logic [sied_pkg::CH_N-1:0] fr_data =
        frame_q[sied_pkg::ADDR_LSB-1:sied_pkg::DATA_LSB];
    wire logic hit_en = (fr_addr == sied_pkg::ADDR_CHAN_EN);
    wire logic hit_dir = (fr_addr == sied_pkg::ADDR_DIR_SEL);
    wire logic wr_en = frame_ev && fr_wr && hit_en;
    wire logic wr_dir = frame_ev && fr_wr && hit_dir;

    logic [sied_pkg::CH_N-1:0] en_q;
    logic [sied_pkg::DIR_N-1:0] dir_q;
    wire logic [sied_pkg::CH_N-1:0] rd_data =
        hit_en ? en_q :
        hit_dir ? {{(sied_pkg::CH_N-sied_pkg::DIR_N){1'b0}}, dir_q} :
        sied_pkg::RD_ZERO;

    always_ff @(posedge sys_clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            en_q <= sied_pkg::CHAN_EN_RST;
            dir_q <= sied_pkg::DIR_SEL_RST;
            reply_q <= '0;
        end
        else
        begin
            // Applied at once; host halts operation around it
            if (wr_en)
                en_q <= fr_data;
            if (wr_dir)
                dir_q <= fr_data[sied_pkg::DIR_N-1:0];
            if (frame_ev)
                reply_q <= {1'b0, fr_addr, rd_data, 1'b0};
        end
    end

    assign chan_enable = en_q;
    // A one here means sink, CURRENT_SOURCE_MODE means source
    assign source_sink_choice_bit = dir_q;

    sied_poll_seq #(
        .SLOT_CYCLES(SLOT_CYCLES),
        .CH_N(sied_pkg::CH_N)
    ) u_seq (
        .sys_clk(sys_clk),
        .rst_n(rst_sync_n),
        .chan_en(en_q),
        .run(op_trigger),
        .poll_en(poll_enable),
        .chan_q(poll_chan),
        .sample_q(poll_sample),
        .continuous_q(continuous_mode)
    );

    // -------------------------------------------------
    // Checks
    // -------------------------------------------------
    sequence s_wr_en;
        frame_ev && fr_wr && hit_en;
    endsequence
    sequence s_wr_dir;
        frame_ev && fr_wr && hit_dir;
    endsequence

    a_en_write: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        s_wr_en |=> chan_enable == $past(fr_data))
        else $error("enable write lost");
    a_en_hold: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        !wr_en |=> $stable(chan_enable))
        else $error("enable changed without write");
    a_dir_write: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        s_wr_dir |=> source_sink_choice_bit ==
            $past(fr_data[sied_pkg::DIR_N-1:0]))
        else $error("direction write lost");
    a_dir_hold: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        !wr_dir |=> $stable(source_sink_choice_bit))
        else $error("direction changed without write");
    a_dir_reserved: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        frame_ev && hit_dir |=>
            reply_q[sied_pkg::ADDR_LSB-1:sied_pkg::DIR_N+1] == '0)
        else $error("reserved direction bits not zero");
    // Live bits of the reply must track the outputs driving the pins
    a_dir_readback: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        frame_ev && hit_dir && !fr_wr |=>
            reply_q[sied_pkg::DIR_N:sied_pkg::DATA_LSB] ==
            source_sink_choice_bit)
        else $error("direction readback wrong");
    a_reply_addr: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        frame_ev |=> reply_q[sied_pkg::WR_BIT-1:sied_pkg::ADDR_LSB] ==
            $past(fr_addr))
        else $error("reply address mismatch");
    a_en_readback: assert property (
        @(posedge sys_clk) disable iff (!rst_sync_n)
        frame_ev && hit_en && !fr_wr |=>
            reply_q[sied_pkg::ADDR_LSB-1:sied_pkg::DATA_LSB] == chan_enable)
        else $error("enable readback wrong");
    a_frame_toggle: assert property (
        @(posedge spi_sclk) disable iff (!rst_n)
        last_bit && !spi_cs_n |=> req_tgl_q != $past(req_tgl_q))
        else $error("frame end not signalled");
endmodule
`default_nettype wire

// >>> bench/sied_host.sv
// Purpose: Host model driving 32-bit register frames on the link
// Assumes: Link clock idles low, sampled on rise, changed on fall
// Notes: Clock stands still between frames; data line is inverted once after the last bit, then holds
`timescale 1ns/1ps
`default_nettype none
module sied_host (
    output logic spi_sclk,
    output logic spi_cs_n,
    output logic spi_mosi,
    input wire logic spi_miso
);
    localparam real HALF_NS = 62.5;
    initial
    begin
        spi_sclk = 1'b0;
        spi_cs_n = 1'b1;
        spi_mosi = 1'b0;
    end
    // ------------------------------------------------------------
    // Frame transfer, n edges; short n gives a discarded frame
    // ------------------------------------------------------------
    task automatic xfer(input logic [31:0] tx, input int n,
        output logic [31:0] rx);
        rx = 32'h0000_0000;
        spi_cs_n = 1'b0;
        for (int i = 0; i < n; i++)
        begin
            spi_mosi = tx[31-i];
            #(HALF_NS);
            spi_sclk = 1'b1;
            rx[31-i] = spi_miso;
            #(HALF_NS);
            spi_sclk = 1'b0;
        end
        // Inverted so a stale bit is never mistaken for data
        spi_mosi = ~spi_mosi;
        #(HALF_NS);
        spi_cs_n = 1'b1;
        #(4 * HALF_NS);
    endtask
endmodule
`default_nettype wire

// >>> bench/sied_top_tb.sv
// Purpose: Self-checking bench for enable and direction registers
// Assumes: Host model makes frames; bench drives the run inputs
// Notes: Short slot count keeps polling runs brief
`timescale 1ns/1ps
`default_nettype none
module sied_top_tb;
    localparam int SLOT = 8;
    logic sys_clk, rst_n, op_trigger, poll_enable, rel_pat, quiet;
    logic spi_sclk, spi_cs_n, spi_mosi, miso_w;
    logic spi_miso_o, spi_miso_oe, poll_sample, continuous_mode;
    logic [23:0] chan_enable;
    logic [9:0] source_sink_choice_bit;
    logic [4:0] poll_chan;
    int bad_count = 0, checks = 0, seed = 13, cyc = 0;
    int gap = -1, last_ch = 23, pulses = 0, chen = 0, dir = 0;
    logic [31:0] rep_q[$];
    // Released line shows a changing pattern, not its last bit
    assign miso_w = spi_miso_oe ? spi_miso_o : rel_pat;
    sied_host u_host (.spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso(miso_w));
    sied_top #(.SLOT_CYCLES(SLOT)) u_dut (.sys_clk(sys_clk),
        .rst_n(rst_n), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .spi_miso_o(spi_miso_o),
        .spi_miso_oe(spi_miso_oe), .op_trigger(op_trigger),
        .poll_enable(poll_enable), .chan_enable(chan_enable),
        .source_sink_choice_bit(source_sink_choice_bit),
        .poll_chan(poll_chan), .poll_sample(poll_sample),
        .continuous_mode(continuous_mode));
    // ------------------------------------------------------------
    // Clock, timeout, checks and model
    // ------------------------------------------------------------
    initial
    begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk)
    begin
        rel_pat <= ~rel_pat;
        cyc++;
        if (cyc == 60000)
        begin
            bad_count++;
            print_verdict();
        end
    end
    task automatic chk_out(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic chk_rep(input logic [31:0] g);
        chk_out("reply", rep_q.pop_front(), g);
    endtask
    task automatic print_verdict();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    function automatic int next_en(input int c);
        int k;
        k = c;
        for (int i = 0; i < 24; i++)
        begin
            k = (k + 1) % 24;
            if (chen[k])
                return k;
        end
        return c;
    endfunction
    task automatic do_op(input logic wr, input logic [5:0] a,
        input logic [23:0] d);
        logic [31:0] rx;
        int old;
        old = (a == 6'h1B) ? chen : (a == 6'h1C) ? dir : 0;
        u_host.xfer({wr, a, d, 1'b0}, 32, rx);
        if (rep_q.size() > 0)
            chk_rep(rx);
        rep_q.push_back({1'b0, a, old[23:0], 1'b0});
        if (wr && a == 6'h1B)
            chen = d;
        if (wr && a == 6'h1C)
            dir = d & 24'h00_03FF;
        chk_out("chan_enable", chen, chan_enable);
        chk_out("source_sink", dir, source_sink_choice_bit);
        chk_out("miso_oe", 0, spi_miso_oe);
    endtask
    always @(negedge sys_clk)
    begin
        if (gap >= 0)
            gap++;
        if (poll_sample === 1'b1)
        begin
            pulses++;
            if (quiet !== 1'b0)
                chk_out("poll_sample", 0, 1);
            last_ch = next_en(last_ch);
            chk_out("poll_chan", last_ch, poll_chan);
            if (gap >= 0)
                chk_out("poll slot", SLOT, gap);
            gap = 0;
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        logic [31:0] rx;
        rst_n = 1'b0;
        op_trigger = 1'b0;
        poll_enable = 1'b0;
        quiet = 1'b1;
        rel_pat = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 rst_n = 1'b1;
        repeat (6) @(posedge sys_clk);
        // Keeps every link edge off the system clock edges
        #1;
        chk_out("chan_enable", 0, chan_enable);
        chk_out("source_sink", 0, source_sink_choice_bit);
        chk_out("continuous_mode", 0, continuous_mode);
        repeat (12)
            do_op(1'($random(seed)), 6'h1B + 6'($random(seed) & 3),
                24'($random(seed)));
        do_op(1'b1, 6'h1C, 24'hFF_FFFF);
        do_op(1'b1, 6'h1B, 24'hFF_FFFF);
        u_host.xfer({1'b1, 6'h1B, 24'h00_0000, 1'b0}, 16, rx);
        chk_out("chan_enable", chen, chan_enable);
        do_op(1'b0, 6'h1B, 24'h00_0000);
        do_op(1'b0, 6'h1C, 24'h00_0000);
        do_op(1'b1, 6'h1B, 24'($random(seed)) | 24'h80_0001);
        @(posedge sys_clk);
        #1 quiet = 1'b0;
        op_trigger = 1'b1;
        poll_enable = 1'b1;
        repeat (30 * SLOT) @(posedge sys_clk);
        #1 poll_enable = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 quiet = 1'b1;
        chk_out("continuous_mode", 1, continuous_mode);
        chk_out("pulse count", 1, 32'(pulses >= 25));
        repeat (3 * SLOT) @(posedge sys_clk);
        #1 op_trigger = 1'b0;
        repeat (2) @(posedge sys_clk);
        #1 chk_out("continuous_mode", 0, continuous_mode);
        do_op(1'b1, 6'h1B, 24'h00_0000);
        @(posedge sys_clk);
        #1 op_trigger = 1'b1;
        poll_enable = 1'b1;
        // Nothing enabled: any pulse here is flagged by the monitor
        repeat (4 * SLOT) @(posedge sys_clk);
        #1 op_trigger = 1'b0;
        // Flush frame so the last write's reply is compared too
        do_op(1'b0, 6'h1C, 24'h00_0000);
        print_verdict();
    end
endmodule
`default_nettype wire
